// ==== rtl/aitc_timer.sv ====
// Purpose: control register, prescaler, current value counter and trigger pulse
// Assumes: start and end values come from neighbouring register logic
// Notes: all state is synchronous to core_clk, reset by srst
`timescale 1ns/1ns
module aitc_timer (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // neighbouring value registers
  input wire logic [15:0] start_value,
  input wire logic [15:0] end_value,
  // timer outputs
  output logic [15:0] current_value,
  output logic injection_trigger_out
);
  logic [15:0] control_register;
  logic [aitc_pkg::PRESC_CNT_W-1:0] presc_cnt;
  logic [aitc_pkg::PRESC_CNT_W-1:0] presc_lim;
  logic [aitc_pkg::PRESC_W-1:0] prescale_code;
  logic count_enable_bit;
  logic count_direction;
  logic reload_enable;
  logic continue_stop_select;
  logic trigger_output_enable;
  logic count_tick;
  logic load_pending;
  logic at_end;
  logic at_end_q;
  logic end_edge;
  logic edge_q;
  logic [15:0] next_value;

  // control register address match, shared by the write and read paths
  function automatic logic is_ctrl_addr(input logic [15:0] addr);
    return addr == aitc_pkg::CTRL_OFFSET;
  endfunction

  assign count_enable_bit = control_register[aitc_pkg::BIT_ENABLE];
  assign count_direction = control_register[aitc_pkg::BIT_DIRECTION];
  assign reload_enable = control_register[aitc_pkg::BIT_RELOAD];
  assign continue_stop_select = control_register[aitc_pkg::BIT_CONT_STOP];
  assign trigger_output_enable = control_register[aitc_pkg::BIT_TRIG_EN];
  assign prescale_code = control_register[aitc_pkg::PRESC_LSB +: aitc_pkg::PRESC_W];

  // control register write, upper bits never stored
  always_ff @(posedge core_clk) begin
    if (srst) begin
      control_register <= aitc_pkg::CTRL_RESET;
    end else if (reg_wr && is_ctrl_addr(reg_addr)) begin
      control_register <= reg_wdata & aitc_pkg::CTRL_WMASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd && is_ctrl_addr(reg_addr)) begin
      reg_rdata <= control_register & aitc_pkg::CTRL_WMASK;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // prescaler runs on core_clk, the base clock; limit is 2**(2+code)-1
  always_comb begin
    presc_lim = '0;
    for (int i = 0; i < aitc_pkg::PRESC_CNT_W; i++) begin
      if (i < aitc_pkg::PRESC_BASE_EXP + int'(prescale_code)) begin
        presc_lim[i] = 1'b1;
      end
    end
  end

  assign count_tick = count_enable_bit && ((presc_cnt & presc_lim) == presc_lim);

  always_ff @(posedge core_clk) begin
    if (srst || !count_enable_bit) begin
      presc_cnt <= '0;
    end else begin
      presc_cnt <= presc_cnt + 1'b1;
    end
  end

  // start value is loaded on the first tick after enable rises
  always_ff @(posedge core_clk) begin
    if (srst || !count_enable_bit) begin
      load_pending <= 1'b1;
    end else if (count_tick) begin
      load_pending <= 1'b0;
    end
  end

  assign at_end = current_value == end_value;

  always_comb begin
    next_value = current_value;
    if (load_pending) begin
      next_value = start_value;
    end else if (at_end && reload_enable) begin
      next_value = start_value;
    end else if (at_end && !continue_stop_select) begin
      next_value = current_value;
    end else if (count_direction) begin
      next_value = current_value + 16'h0001;
    end else begin
      next_value = current_value - 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      current_value <= aitc_pkg::VALUE_RESET;
    end else if (count_tick) begin
      current_value <= next_value;
    end
  end

  // trigger: rising edge of equality, stretched to two base cycles
  assign end_edge = count_enable_bit && at_end && !at_end_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      at_end_q <= 1'b0;
      edge_q <= 1'b0;
      injection_trigger_out <= 1'b0;
    end else begin
      at_end_q <= at_end;
      edge_q <= end_edge;
      injection_trigger_out <= trigger_output_enable && (end_edge || edge_q);
    end
  end

  sequence s_tick_mid;
    count_tick && !load_pending && !at_end;
  endsequence

  sequence s_tick_end;
    count_tick && !load_pending && at_end;
  endsequence

  sequence s_pulse;
    injection_trigger_out [*2];
  endsequence

  AST_DISABLED_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    !count_enable_bit |=> $stable(current_value))
    else $error("value changed while disabled");
  AST_DOWN: assert property (@(posedge core_clk) disable iff (srst)
    s_tick_mid and !count_direction |=> current_value == $past(current_value) - 16'h0001)
    else $error("down count wrong");
  AST_UP: assert property (@(posedge core_clk) disable iff (srst)
    s_tick_mid and count_direction |=> current_value == $past(current_value) + 16'h0001)
    else $error("up count wrong");
  AST_RELOAD: assert property (@(posedge core_clk) disable iff (srst)
    s_tick_end and reload_enable |=> current_value == $past(start_value))
    else $error("reload missed");
  AST_CONTINUE: assert property (@(posedge core_clk) disable iff (srst)
    s_tick_end and !reload_enable && continue_stop_select && count_direction
    |=> current_value == $past(current_value) + 16'h0001)
    else $error("continue mode did not count");
  AST_STOP: assert property (@(posedge core_clk) disable iff (srst)
    s_tick_end and !reload_enable && !continue_stop_select |=> $stable(current_value))
    else $error("stop mode did not freeze");
  AST_FIRST_LOAD: assert property (@(posedge core_clk) disable iff (srst)
    count_tick && load_pending |=> current_value == $past(start_value))
    else $error("start value not loaded on first tick");
  AST_TRIG_PULSE: assert property (@(posedge core_clk) disable iff (srst)
    end_edge && trigger_output_enable ##1 trigger_output_enable |-> s_pulse)
    else $error("trigger pulse not two cycles");
  AST_TRIG_OFF: assert property (@(posedge core_clk) disable iff (srst)
    !trigger_output_enable |=> !injection_trigger_out)
    else $error("trigger high while disabled");
  AST_MIN_DIV: assert property (@(posedge core_clk) disable iff (srst)
    count_tick && $stable(control_register) |=> !count_tick [*3])
    else $error("count tick faster than divide by four");
  AST_HIGH_ZERO: assert property (@(posedge core_clk) disable iff (srst)
    reg_rd |=> reg_rdata[15:10] == 6'h00)
    else $error("upper control bits not zero");
  // read data stands one cycle only, then returns to zero
  AST_RDATA_IDLE: assert property (@(posedge core_clk) disable iff (srst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not cleared");
  AST_CONTINUE_DOWN: assert property (@(posedge core_clk) disable iff (srst)
    s_tick_end and !reload_enable && continue_stop_select && !count_direction
    |=> current_value == $past(current_value) - 16'h0001)
    else $error("continue mode did not count down");
  AST_PRESC_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
    !count_enable_bit |=> presc_cnt == '0)
    else $error("prescaler ran while disabled");
  AST_LOAD_ONCE: assert property (@(posedge core_clk) disable iff (srst)
    count_tick && load_pending |=> !load_pending)
    else $error("start load repeated");
  AST_PULSE_END: assert property (@(posedge core_clk) disable iff (srst)
    s_pulse |=> !injection_trigger_out)
    else $error("trigger pulse longer than two cycles");
  AST_NO_TRIG_IDLE: assert property (@(posedge core_clk) disable iff (srst)
    !count_enable_bit && !edge_q |=> !injection_trigger_out)
    else $error("trigger without a running timer");
endmodule // aitc_timer

// ==== rtl/aitc_pkg.sv ====
// Purpose: constants for the injection trigger timer control block
// Assumes: 16-bit control register on the CPU-side register port
// Notes: base clock equals core_clk, so one base cycle is one core_clk cycle
package aitc_pkg;
  localparam logic [15:0] CTRL_OFFSET = 16'hC000;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // writable bits 9..0, bits 15..10 read as zero
  localparam logic [15:0] CTRL_WMASK = 16'h03FF;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_DIRECTION = 1;
  localparam int BIT_RELOAD = 2;
  localparam int BIT_CONT_STOP = 3;
  localparam int BIT_TRIG_EN = 4;
  localparam int BIT_CLK_MODE = 5;
  localparam int PRESC_LSB = 6;
  localparam int PRESC_W = 4;
  // smallest division is 2**PRESC_BASE_EXP, largest 2**(PRESC_BASE_EXP+15)
  localparam int PRESC_BASE_EXP = 2;
  localparam int PRESC_CNT_W = 18;
  localparam int BASE_CLK_NS = 100;
  localparam int TRIG_PULSE_NS = 2 * BASE_CLK_NS;
  localparam int TRIG_PULSE_CYC = TRIG_PULSE_NS / BASE_CLK_NS;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
endpackage

// ==== sim/aitc_capture_model.sv ====
// Purpose: capture input model that counts trigger pulses and measures their width
// Assumes: trigger is sampled on core_clk like a synchronous capture input
// Notes: pulse_len holds the width of the last complete pulse in cycles
`timescale 1ns/1ns
module aitc_capture_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // trigger from the timer
  input wire logic trig_in,
  // observations
  output logic [7:0] edge_count,
  output logic [7:0] pulse_len
);
  logic trig_q;
  logic [7:0] run_len;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trig_q <= 1'b0;
      edge_count <= 8'h00;
      run_len <= 8'h00;
      pulse_len <= 8'h00;
    end else begin
      trig_q <= trig_in;
      // each rising edge is one injection request
      if (trig_in && !trig_q) edge_count <= edge_count + 8'h01;
      run_len <= trig_in ? run_len + 8'h01 : 8'h00;
      if (!trig_in && trig_q) pulse_len <= run_len;
    end
  end
endmodule // aitc_capture_model

// ==== sim/test_aitc_timer.sv ====
// Purpose: self-checking bench for the injection trigger timer control
// Assumes: inputs change 10 ns after the rising edge of core_clk
// Notes: software side writes configuration first, then the same value with the enable bit set
`timescale 1ns/1ns
module test_aitc_timer;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] start_value = 16'h0000;
  logic [15:0] end_value = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] current_value;
  logic injection_trigger_out;
  logic [7:0] edge_count;
  logic [7:0] pulse_len;
  int errors = 0;
  int checks_done = 0;
  always #50 core_clk = ~core_clk;
  aitc_timer dut_u (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .start_value(start_value),
    .end_value(end_value), .current_value(current_value),
    .injection_trigger_out(injection_trigger_out));
  aitc_capture_model cap_u (.core_clk(core_clk), .srst(srst), .trig_in(injection_trigger_out),
    .edge_count(edge_count), .pulse_len(pulse_len));
  task automatic summarize;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    // one idle edge keeps back-to-back strobes apart
    tick(1);
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    d = reg_rdata;
    tick(1);
  endtask
  // waits for the next counter change, checks value and cycles since the last change
  task automatic step(input logic [15:0] exp, input int gap);
    int n;
    logic [15:0] old;
    old = current_value;
    n = 0;
    while (current_value === old && n < 300) begin
      tick(1);
      n++;
    end
    if (n >= 300) begin
      errors++;
      summarize();
    end else begin
      cmp(current_value, exp);
      if (gap > 0) cmp(16'(n), 16'(gap));
    end
  endtask
  task automatic t_regs;
    logic [15:0] d;
    rd(16'hC000, d);
    cmp(d, 16'h0000);
    // clock mode bit stays clear while the upper bits are probed
    wr(16'hC000, 16'hFFDE);
    rd(16'hC000, d);
    cmp(d, 16'h03DE);
    wr(16'hC000, 16'h0000);
    wr(16'hC002, 16'h0001);
    rd(16'hC000, d);
    cmp(d, 16'h0000);
    rd(16'hC002, d);
    cmp(d, 16'h0000);
  endtask
  task automatic t_reload;
    start_value = 16'h0002;
    end_value = 16'h0004;
    wr(16'hC000, 16'h0016);
    wr(16'hC000, 16'h0017);
    step(16'h0002, 0);
    step(16'h0003, 4);
    step(16'h0004, 4);
    step(16'h0002, 4);
    step(16'h0003, 4);
    step(16'h0004, 4);
    tick(4);
    cmp({8'h00, edge_count}, 16'h0002);
    cmp({8'h00, pulse_len}, 16'h0002);
    wr(16'hC000, 16'h0016);
  endtask
  task automatic t_stop;
    start_value = 16'h0005;
    end_value = 16'h0003;
    wr(16'hC000, 16'h0040);
    wr(16'hC000, 16'h0041);
    step(16'h0005, 0);
    step(16'h0004, 8);
    step(16'h0003, 8);
    tick(40);
    cmp(current_value, 16'h0003);
    cmp({8'h00, edge_count}, 16'h0002);
    wr(16'hC000, 16'h0040);
  endtask
  task automatic t_cont;
    start_value = 16'h0000;
    end_value = 16'h0001;
    wr(16'hC000, 16'h00CA);
    wr(16'hC000, 16'h00CB);
    step(16'h0000, 0);
    step(16'h0001, 32);
    step(16'h0002, 32);
    wr(16'hC000, 16'h00CA);
    tick(80);
    cmp(current_value, 16'h0002);
  endtask
  // down count through the end value in continue mode, trigger enabled
  task automatic t_down;
    start_value = 16'h0001;
    end_value = 16'h0000;
    wr(16'hC000, 16'h0018);
    wr(16'hC000, 16'h0019);
    step(16'h0001, 0);
    step(16'h0000, 4);
    step(16'hFFFF, 4);
    tick(4);
    cmp({8'h00, edge_count}, 16'h0003);
    cmp({8'h00, pulse_len}, 16'h0002);
    wr(16'hC000, 16'h0018);
  endtask
  initial begin
    tick(8);
    srst = 1'b0;
    t_regs();
    t_reload();
    t_stop();
    t_cont();
    t_down();
    summarize();
  end
endmodule // test_aitc_timer
